// ==== verilog/flash_row_writer_regs.svh ====
/*
 * Register offsets, field positions, reset values and timing counts of the
 * flash row writer. Assumes an Avalon-MM slave with a 32-bit word per register.
 */
`ifndef FLASH_ROW_WRITER_REGS_SVH
`define FLASH_ROW_WRITER_REGS_SVH

// ==========================================================
// Register byte offsets
`define FRW_ADDR_LOW_OFS   5'h00
`define FRW_ADDR_HIGH_OFS  5'h04
`define FRW_WDATA_LOW_OFS  5'h08
`define FRW_WDATA_HIGH_OFS 5'h0c
`define FRW_CONTROL_OFS    5'h10
`define FRW_UNLOCK_OFS     5'h14

// ==========================================================
// Control register fields
`define FRW_WRITE_ENABLE_BIT_BIT  0
`define FRW_CONFIG_SPACE_SELECT_BIT  1
`define FRW_LATCH_ONLY_BIT_BIT  2
`define FRW_ERASE_BIT 3
`define FRW_BUSY_BIT  4

// ==========================================================
// Reset values and constants
`define FRW_BLANK_WORD   14'h3fff
`define FRW_UNLOCK_KEY1  8'h55
`define FRW_UNLOCK_KEY2  8'haa
`define FRW_PROG_TIME_US 2
`define FRW_PROG_CYCLES  ((`FRW_PROG_TIME_US * 40) / 1)

`endif

// ==== verilog/flash_row_writer_pkg.sv ====
/*
 * Types of the flash row writer.
 * Assumes the register header is included by the design file.
 */
`default_nettype none
package flash_row_writer_pkg;
	// ==========================================================
	// Sequencer states, Gray coded along idle-key-program-blank
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_KEY1  = 3'b001,
		ST_PROG  = 3'b011,
		ST_BLANK = 3'b010
	} seq_state_t;

	// ==========================================================
	// Request to the flash array
	typedef struct packed {
		logic        prog;
		logic        erase;
		logic [9:0]  row;
	} array_req_t;
endpackage
`default_nettype wire

// ==== verilog/program_flash_row_writer.sv ====
/*
 * Flash row writer: latch bank, unlock sequence and row program/erase sequencer
 * behind an Avalon-MM slave. Assumes a flash array that accepts a row request
 * with the full latch bank and needs a fixed time to complete.
 */
// How it works
// - Starting a program never erases; software must only program blank words.
// - Erase works on whole rows, one row per operation, never single words.
// - One program writes at most the 32 latches of one row.
// - Row is address bits 14:5, the low five bits pick the latch.
// - Latch loading and programming stay inside the addressed row.
// - Completing a program resets every latch to 0x3FFF.
// - Completing an erase also resets every latch to 0x3FFF.
// - With latch-only set and erase clear, an unlock only copies the data pair into a latch.
// - With latch-only and erase both clear, an unlock loads the addressed latch and programs the row.
// - A broken unlock sequence loads nothing and starts nothing.
`timescale 1ns/1ps
`default_nettype none
`include "flash_row_writer_regs.svh"

module program_flash_row_writer #(
	parameter int LATCHES    = 32,
	parameter int WORD_W     = 14,
	parameter int PROG_TICKS = `FRW_PROG_CYCLES
) (
	input  wire logic                        ref_clk,
	input  wire logic                        rst_b,
	input  wire logic                        clk_en,
	input  wire logic [4:0]                  avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [31:0]                 avs_writedata,
	output logic      [31:0]                 avs_readdata,
	output logic                             avs_waitrequest,
	output var flash_row_writer_pkg::array_req_t array_req,
	output logic      [LATCHES*WORD_W-1:0]   array_wdata,
	input  wire logic                        array_done
);
	localparam int LW = $clog2(LATCHES);

	// ==========================================================
	// Registers
	logic [7:0]        addr_low_reg;
	logic [6:0]        addr_high_reg;
	logic [7:0]        wdata_low_reg;
	logic [5:0]        wdata_high_reg;
	logic              write_enable_bit_reg;
	logic              config_space_select_reg;
	logic              latch_only_bit_reg;
	logic              erase_reg;
	logic              busy_reg;
	logic              ack_reg;
	// Waitrequest kept in its own flop so the port comes straight from a register
	logic              wait_reg;
	logic [31:0]       rdata_reg;
	logic [15:0]       tick_reg;
	logic [WORD_W-1:0] latch_reg [LATCHES];
	flash_row_writer_pkg::seq_state_t state_reg;
	flash_row_writer_pkg::seq_state_t state_next;
	flash_row_writer_pkg::array_req_t req_reg;

	// ==========================================================
	// Decode
	wire         wr_hit      = avs_write & ~ack_reg;
	wire         rd_hit      = avs_read & ~ack_reg;
	wire         wr_ctrl     = wr_hit && avs_address == `FRW_CONTROL_OFS;
	wire         wr_unlock   = wr_hit && avs_address == `FRW_UNLOCK_OFS;
	wire [7:0]   key_byte    = avs_writedata[7:0];
	wire         key_ok      = write_enable_bit_reg & ~busy_reg & ~config_space_select_reg;
	wire [9:0]   row_sel     = {addr_high_reg, addr_low_reg[7:5]};
	wire [LW-1:0] latch_sel  = addr_low_reg[LW-1:0];
	wire         unlock_done = wr_unlock && state_reg == flash_row_writer_pkg::ST_KEY1
		&& key_byte == `FRW_UNLOCK_KEY2 && key_ok;
	wire         load_latch  = unlock_done & ~erase_reg;
	wire         start_prog  = unlock_done & ~latch_only_bit_reg & ~erase_reg;
	wire         start_erase = unlock_done & erase_reg;
	wire         tick_over   = tick_reg >= 16'(PROG_TICKS);
	wire [WORD_W-1:0] load_word = {wdata_high_reg, wdata_low_reg};

	function automatic logic [31:0] read_mux(input logic [4:0] a, input logic [31:0] ctl,
		input logic [7:0] al, input logic [6:0] ah, input logic [7:0] dl, input logic [5:0] dh);
		case (a)
			`FRW_ADDR_LOW_OFS:   read_mux = {24'h0, al};
			`FRW_ADDR_HIGH_OFS:  read_mux = {25'h0, ah};
			`FRW_WDATA_LOW_OFS:  read_mux = {24'h0, dl};
			`FRW_WDATA_HIGH_OFS: read_mux = {26'h0, dh};
			`FRW_CONTROL_OFS:    read_mux = ctl;
			default:             read_mux = 32'h0;
		endcase
	endfunction

	wire [31:0] ctl_word = {27'h0, busy_reg, erase_reg, latch_only_bit_reg, config_space_select_reg, write_enable_bit_reg};
	wire [31:0] rd_value = read_mux(avs_address, ctl_word, addr_low_reg, addr_high_reg,
		wdata_low_reg, wdata_high_reg);

	// ==========================================================
	// Unlock and sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			flash_row_writer_pkg::ST_IDLE: begin
				if (wr_unlock && key_byte == `FRW_UNLOCK_KEY1 && key_ok)
					state_next = flash_row_writer_pkg::ST_KEY1;
			end
			flash_row_writer_pkg::ST_KEY1: begin
				if (start_prog || start_erase)
					state_next = flash_row_writer_pkg::ST_PROG;
				else if (wr_hit || rd_hit)
					state_next = flash_row_writer_pkg::ST_IDLE;
			end
			flash_row_writer_pkg::ST_PROG: begin
				if (array_done || tick_over)
					state_next = flash_row_writer_pkg::ST_BLANK;
			end
			flash_row_writer_pkg::ST_BLANK: state_next = flash_row_writer_pkg::ST_IDLE;
			default: state_next = flash_row_writer_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= flash_row_writer_pkg::ST_IDLE;
			busy_reg  <= 1'b0;
			tick_reg  <= 16'h0;
			req_reg   <= '0;
		end else if (clk_en) begin
			state_reg <= state_next;
			busy_reg  <= state_next == flash_row_writer_pkg::ST_PROG
				|| state_next == flash_row_writer_pkg::ST_BLANK;
			tick_reg  <= state_reg == flash_row_writer_pkg::ST_PROG ? tick_reg + 16'h1 : 16'h0;
			req_reg.prog  <= state_next == flash_row_writer_pkg::ST_PROG && (start_prog || req_reg.prog);
			req_reg.erase <= state_next == flash_row_writer_pkg::ST_PROG && (start_erase || req_reg.erase);
			if (unlock_done)
				req_reg.row <= row_sel;
		end
	end

	// ==========================================================
	// Latch bank
	genvar gi;
	generate
		for (gi = 0; gi < LATCHES; gi++) begin : g_latch
			always_ff @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					latch_reg[gi] <= `FRW_BLANK_WORD;
				end else if (clk_en) begin
					if (state_reg == flash_row_writer_pkg::ST_BLANK)
						latch_reg[gi] <= `FRW_BLANK_WORD;
					// Only the addressed latch of the row
					else if (load_latch && latch_sel == LW'(gi))
						latch_reg[gi] <= load_word;
				end
			end
			// Full bank goes to the row
			assign array_wdata[gi*WORD_W +: WORD_W] = latch_reg[gi];
		end
	endgenerate

	// ==========================================================
	// Avalon slave: one wait cycle, answer on the second edge
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			addr_low_reg   <= 8'h0;
			addr_high_reg  <= 7'h0;
			wdata_low_reg  <= 8'h0;
			wdata_high_reg <= 6'h0;
			write_enable_bit_reg       <= 1'b0;
			config_space_select_reg       <= 1'b0;
			latch_only_bit_reg       <= 1'b0;
			erase_reg      <= 1'b0;
			ack_reg        <= 1'b0;
			wait_reg       <= 1'b1;
			rdata_reg      <= 32'h0;
		end else if (clk_en) begin
			ack_reg  <= (avs_read | avs_write) & ~ack_reg;
			wait_reg <= ~((avs_read | avs_write) & ~ack_reg);
			if (rd_hit)
				rdata_reg <= rd_value;
			if (wr_hit && !busy_reg) begin
				case (avs_address)
					`FRW_ADDR_LOW_OFS:   addr_low_reg   <= avs_writedata[7:0];
					`FRW_ADDR_HIGH_OFS:  addr_high_reg  <= avs_writedata[6:0];
					`FRW_WDATA_LOW_OFS:  wdata_low_reg  <= avs_writedata[7:0];
					`FRW_WDATA_HIGH_OFS: wdata_high_reg <= avs_writedata[5:0];
					default: ;
				endcase
			end
			if (wr_ctrl) begin
				write_enable_bit_reg  <= avs_writedata[`FRW_WRITE_ENABLE_BIT_BIT];
				config_space_select_reg  <= avs_writedata[`FRW_CONFIG_SPACE_SELECT_BIT];
				latch_only_bit_reg  <= avs_writedata[`FRW_LATCH_ONLY_BIT_BIT];
				erase_reg <= avs_writedata[`FRW_ERASE_BIT];
			end
		end
	end

	assign avs_waitrequest = wait_reg;
	assign avs_readdata    = rdata_reg;
	assign array_req       = req_reg;
endmodule // program_flash_row_writer
`default_nettype wire

// ==== sim/flash_row_writer_properties.sv ====
/* Port checks of the flash row writer.
   Assumes binding to the top with its parameters. */
`timescale 1ns/1ps
`default_nettype none
module flash_row_writer_properties #(
	parameter int LATCHES    = 32,
	parameter int WORD_W     = 14,
	parameter int PROG_TICKS = 80
) (
	input wire logic                          ref_clk,
	input wire logic                          rst_b,
	input wire logic                          clk_en,
	input wire logic                          avs_read,
	input wire logic                          avs_write,
	input wire logic                          avs_waitrequest,
	input wire flash_row_writer_pkg::array_req_t array_req,
	input wire logic [LATCHES*WORD_W-1:0]     array_wdata,
	input wire logic                          array_done
);
	localparam int MAXT = PROG_TICKS + 4;
	wire op = array_req.prog | array_req.erase;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// =====
	// Checks
	sequence s_ack; !avs_waitrequest ##1 avs_waitrequest; endsequence
	property p_ack; (avs_read | avs_write) & avs_waitrequest & clk_en |=> s_ack; endproperty
	a_ack: assert property (p_ack) else $error("bus answer late");
	property p_excl; !(array_req.prog & array_req.erase); endproperty
	a_excl: assert property (p_excl) else $error("program with erase");
	property p_row; op && $past(op) |-> $stable(array_req.row); endproperty
	a_row: assert property (p_row) else $error("row moved");
	property p_bound; $rose(op) |-> ##[1:MAXT] !op; endproperty
	a_bound: assert property (p_bound) else $error("busy stuck");
	property p_bprog; $fell(array_req.prog) |-> ##[1:3] (&array_wdata); endproperty
	a_bprog: assert property (p_bprog) else $error("latches not blank");
	property p_bera; $fell(array_req.erase) |-> ##[1:3] (&array_wdata); endproperty
	a_bera: assert property (p_bera) else $error("latches not blank");
	property p_hold; !$stable(array_wdata) |-> $past(avs_write) || $past(avs_write, 2) || op || $past(op) || $past(op, 2);
	endproperty
	a_hold: assert property (p_hold) else $error("latch changed alone");
	property p_start; $rose(op) |-> $past(avs_write) || $past(avs_write, 2); endproperty
	a_start: assert property (p_start) else $error("start without unlock");
	property p_done; op && array_done |=> !op; endproperty
	a_done: assert property (p_done) else $error("done ignored");
endmodule // flash_row_writer_properties
bind program_flash_row_writer flash_row_writer_properties #(.LATCHES(LATCHES), .WORD_W(WORD_W),
	.PROG_TICKS(PROG_TICKS)) u_props (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .array_req(array_req),
	.array_wdata(array_wdata), .array_done(array_done));
`default_nettype wire

// ==== sim/flash_array_model.sv ====
/* Flash array stand-in: ends each request after a few cycles.
   Assumes requests hold until done; slow never answers. */
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
	input wire logic                          ref_clk,
	input wire logic                          rst_b,
	input wire logic                          slow,
	input wire flash_row_writer_pkg::array_req_t array_req,
	input wire logic [447:0]                  array_wdata,
	output logic                              array_done,
	output logic [7:0]                        op_cnt,
	output var flash_row_writer_pkg::array_req_t last_req,
	output logic [447:0]                      last_data
);
	logic [3:0] age_reg;
	wire op = array_req.prog | array_req.erase;
	// =====
	// whole row
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			age_reg <= 4'h0;
			array_done <= 1'b0;
			op_cnt <= 8'h00;
			last_req <= '0;
			last_data <= '0;
		end else begin
			// Saturates so a long request is counted once only
			age_reg <= op ? (age_reg == 4'hf ? age_reg : age_reg + 4'h1) : 4'h0;
			array_done <= op && !slow && age_reg == 4'h2;
			if (op && age_reg == 4'h0) begin
				op_cnt <= op_cnt + 8'h01;
				last_req <= array_req;
				last_data <= array_wdata;
			end
		end
	end
endmodule // flash_array_model
`default_nettype wire

// ==== sim/tb.sv ====
/* Self-checking bench of the flash row writer.
   Assumes the array model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic ref_clk, rst_b, clk_en, avs_read, avs_write, slow, avs_waitrequest, array_done;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rv;
	flash_row_writer_pkg::array_req_t array_req, last_req;
	logic [447:0] array_wdata, last_data, bank;
	logic [7:0] op_cnt;
	int err_total, compares;
	localparam logic [68:0] ROWS [6] = '{{5'h00, 32'hffffffff, 32'hff}, {5'h04, 32'hffffffff, 32'h7f},
		{5'h08, 32'hffffffff, 32'hff}, {5'h0c, 32'hffffffff, 32'h3f}, {5'h10, 32'hffffffff, 32'hf},
		{5'h18, 32'hffffffff, 32'h0}};
	program_flash_row_writer #(.PROG_TICKS(40)) DUT (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .array_req(array_req),
		.array_wdata(array_wdata), .array_done(array_done));
	flash_array_model u_array (.ref_clk(ref_clk), .rst_b(rst_b), .slow(slow), .array_req(array_req),
		.array_wdata(array_wdata), .array_done(array_done), .op_cnt(op_cnt), .last_req(last_req),
		.last_data(last_data));
	// =====
	// Tasks
	task automatic chk(input logic [447:0] seen, input logic [447:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: %h", $time, seen);
		end
	endtask
	task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		// Only the watchdog ends an unanswered request
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		rv = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic put(input logic [3:0] ctl, input logic [7:0] lo, input logic [13:0] dat, input logic [7:0] k2);
		acc(1'b1, 5'h10, {28'h0, ctl});
		acc(1'b1, 5'h00, {24'h0, lo});
		acc(1'b1, 5'h08, {24'h0, dat[7:0]});
		acc(1'b1, 5'h0c, {26'h0, dat[13:8]});
		acc(1'b1, 5'h14, 32'h55);
		acc(1'b1, 5'h14, {24'h0, k2});
	endtask
	task automatic idle_wait;
		for (int n = 0; n < 30; n++) begin
			acc(1'b0, 5'h10, 32'h0);
			if (rv[4] === 1'b0)
				break;
		end
	endtask
	task automatic tally_and_finish;
		if (err_total == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		#50000;
		err_total++;
		tally_and_finish;
	end
	initial begin
		{rst_b, avs_read, avs_write, slow, avs_address, avs_writedata} = '0;
		clk_en = 1'b1;
		err_total = 0;
		compares = 0;
		bank = '1;
		repeat (20) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		chk(array_wdata, bank);
		chk(array_req, 0);
		foreach (ROWS[i]) begin
			acc(1'b1, ROWS[i][68:64], ROWS[i][63:32]);
			acc(1'b0, ROWS[i][68:64], 32'h0);
			chk(rv, ROWS[i][31:0]);
		end
		// Latch only, last slot of row
		acc(1'b1, 5'h04, 32'h2d);
		put(4'h5, 8'hbf, 14'h1234, 8'haa);
		bank[31*14 +: 14] = 14'h1234;
		chk(array_wdata, bank);
		chk(op_cnt, 0);
		// Broken or refused unlocks
		acc(1'b1, 5'h14, 32'h55);
		acc(1'b1, 5'h08, 32'h11);
		acc(1'b1, 5'h14, 32'haa);
		chk(array_wdata, bank);
		put(4'h5, 8'ha0, 14'h0777, 8'hab);
		chk(array_wdata, bank);
		put(4'h4, 8'ha0, 14'h0777, 8'haa);
		chk(array_wdata, bank);
		put(4'h7, 8'ha0, 14'h0777, 8'haa);
		chk(array_wdata, bank);
		// Program row 0x16d
		put(4'h1, 8'ha0, 14'h2abc, 8'haa);
		bank[13:0] = 14'h2abc;
		idle_wait;
		chk(op_cnt, 1);
		chk(last_req, {2'b10, 10'h16d});
		chk(last_data, bank);
		chk(array_wdata, {448{1'b1}});
		// Slow array, unlock while busy
		slow <= 1'b1;
		put(4'h1, 8'ha0, 14'h0555, 8'haa);
		acc(1'b0, 5'h10, 32'h0);
		chk(rv[4], 1'b1);
		acc(1'b1, 5'h14, 32'h55);
		acc(1'b1, 5'h14, 32'haa);
		acc(1'b1, 5'h00, 32'h0);
		acc(1'b0, 5'h00, 32'h0);
		chk(rv, 32'ha0);
		idle_wait;
		chk(op_cnt, 2);
		chk(array_wdata, {448{1'b1}});
		slow <= 1'b0;
		// Erase after a latch load
		put(4'h5, 8'ha3, 14'h0123, 8'haa);
		put(4'h9, 8'ha3, 14'h0000, 8'haa);
		idle_wait;
		chk(last_req, {2'b01, 10'h16d});
		chk(array_wdata, {448{1'b1}});
		chk(op_cnt, 3);
		// Row 0x176: latch slot 0 only, then load slot 1 and program
		acc(1'b1, 5'h04, 32'h2e);
		put(4'h5, 8'hc0, 14'h0101, 8'haa);
		put(4'h1, 8'hc1, 14'h0202, 8'haa);
		idle_wait;
		chk(op_cnt, 4);
		chk(last_req, {2'b10, 10'h176});
		chk(last_data, {{420{1'b1}}, 14'h0202, 14'h0101});
		// Clock enable low: request must stay unanswered, nothing written
		clk_en <= 1'b0;
		@(posedge ref_clk);
		avs_address <= 5'h00;
		avs_writedata <= 32'h5a;
		avs_write <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk(avs_waitrequest, 1'b1);
		avs_write <= 1'b0;
		@(posedge ref_clk);
		clk_en <= 1'b1;
		acc(1'b0, 5'h00, 32'h0);
		chk(rv, 32'hc1);
		// Reset in mid-run with a loaded latch
		put(4'h5, 8'hc3, 14'h0abc, 8'haa);
		@(posedge ref_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		chk(avs_waitrequest, 1'b1);
		chk(array_wdata, {448{1'b1}});
		chk(array_req, 0);
		acc(1'b0, 5'h10, 32'h0);
		chk(rv, 32'h0);
		tally_and_finish;
	end
endmodule // tb
`default_nettype wire
